// *** src/sgb_servo_boost.sv ***
/*
 * Third-gain boost before stop and friction torque compensation for the
 * position loop of a servo drive, with an AHB-Lite register slave.
 * Assumes one clock, a sampled position command from the motion controller
 * and first/second gain sets and switching condition supplied by the drive.
 */
// Added by the designer: the register offsets and the AHB-Lite slave port.
`timescale 1ns/1ns
module sgb_servo_boost #(
	parameter int TICK_CYCLES = sgb_pkg::SGB_TICK_CYCLES
) (
	// clock, reset, enable
	input wire logic clk,
	input wire logic rst,
	input wire logic ce,
	// ahb-lite slave
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic [31:0] hrdata,
	output logic hresp,
	// drive state
	input wire logic servoOn,
	input wire logic secondGainCond,
	// position command from the motion controller
	input wire logic posCmdActive,
	input wire logic posCmdFwd,
	// gain sets in and applied gains out
	input wire sgb_pkg::sgb_gains_t firstGains,
	input wire sgb_pkg::sgb_gains_t secondGains,
	output sgb_pkg::sgb_gains_t appliedGains,
	output logic boostActive,
	// torque command path
	input wire logic signed [15:0] torqueCmdIn,
	output logic signed [15:0] torqueCmdOut
);
	import sgb_pkg::*;

	sgb_state_t s_q;
	sgb_state_t s_d;
	logic posMode;
	logic cmdStart;
	logic cmdEnd;
	logic boostOk;
	logic tick;
	logic wr;
	logic accept;
	logic restoreReq;
	logic secActive;
	logic enterThird;
	logic rampThird;
	logic [25:0] posProd;
	logic [25:0] velProd;
	logic [15:0] thirdPos;
	logic [15:0] thirdVel;
	logic signed [17:0] rampDiff;
	logic signed [17:0] rampStep;
	logic signed [17:0] torqueSum;

	// register read mux, fed with the post-write state so reads see writes
	function automatic logic [31:0] regRead(input sgb_state_t v,
		input logic [7:0] a);
		logic [31:0] r;
		r = '0;
		case (a)
			SGB_OFS_INTERVAL: r[13:0] = v.interval;
			SGB_OFS_SCALE: r[9:0] = v.scale;
			SGB_OFS_BIAS: r = {{24{v.bias[7]}}, v.bias};
			SGB_OFS_FWD: r = {{24{v.fwd[7]}}, v.fwd};
			SGB_OFS_REV: r = {{24{v.rev[7]}}, v.rev};
			SGB_OFS_TRANS: r[13:0] = v.trans;
			SGB_OFS_CTRL: r[SGB_CTRL_MODE_LSB +: 2] = v.mode;
			SGB_OFS_STATUS: begin
				r[1:0] = v.gain;
				r[SGB_STAT_BIAS_LSB +: 8] = v.biasCur;
				r[SGB_STAT_FRIC_LSB +: 8] = v.fricCur;
			end
			default: r = '0;
		endcase
		return r;
	endfunction

	// third gain from first gain and scale, clipped to the gain width
	always_comb begin
		posProd = 26'(firstGains.pos * s_q.scale) / SGB_SCALE_DIV;
		velProd = 26'(firstGains.vel * s_q.scale) / SGB_SCALE_DIV;
		thirdPos = (posProd > 26'(SGB_GAIN_MAX)) ? SGB_GAIN_MAX : posProd[15:0];
		thirdVel = (velProd > 26'(SGB_GAIN_MAX)) ? SGB_GAIN_MAX : velProd[15:0];
	end

	// bus handshake: no wait states, but a frozen block stalls the bus
	assign hreadyout = ce;
	assign hresp = 1'b0;
	assign hrdata = s_q.rdata;
	// one driver for the whole struct keeps strict tools content
	assign appliedGains = '{pos: s_q.posGain, vel: s_q.velGain};
	assign boostActive = (s_q.gain == SGB_GAIN_THIRD);
	assign torqueCmdOut = s_q.torque;

	// next state of the whole block
	always_comb begin
		s_d = s_q;
		posMode = (s_q.mode == SGB_MODE_POS) || (s_q.mode == SGB_MODE_FULL);
		cmdStart = posCmdActive && !s_q.cmdPrev;
		cmdEnd = !posCmdActive && s_q.cmdPrev;
		boostOk = servoOn && posMode && (s_q.interval != '0);
		tick = (s_q.tickCnt == 16'(TICK_CYCLES - 1));
		wr = s_q.ahbActive && s_q.ahbWrite;
		accept = hsel && htrans[1] && hready;
		restoreReq = 1'b0;
		enterThird = 1'b0;
		rampThird = 1'b0;
		rampDiff = '0;
		rampStep = '0;

		// data phase of a write
		if (wr) begin
			case (s_q.ahbAddr)
				SGB_OFS_INTERVAL: s_d.interval = hwdata[13:0];
				SGB_OFS_SCALE: s_d.scale = hwdata[9:0];
				SGB_OFS_BIAS: s_d.bias = hwdata[7:0];
				SGB_OFS_FWD: s_d.fwd = hwdata[7:0];
				SGB_OFS_REV: s_d.rev = hwdata[7:0];
				SGB_OFS_TRANS: s_d.trans = hwdata[13:0];
				SGB_OFS_CTRL: begin
					s_d.mode = sgb_mode_t'(hwdata[SGB_CTRL_MODE_LSB +: 2]);
					restoreReq = hwdata[SGB_CTRL_RESTORE_BIT];
				end
				default: ;
			endcase
		end

		// time base, restarted when a boost interval opens
		s_d.tickCnt = tick ? '0 : s_q.tickCnt + 16'h0001;
		s_d.cmdPrev = posCmdActive;
		// a forced fall-back ignores the second-gain condition until it drops
		if (!secondGainCond) begin
			s_d.secInhibit = 1'b0;
		end
		secActive = secondGainCond && !s_q.secInhibit;

		// gain selection
		case (s_q.gain)
			SGB_GAIN_FIRST: begin
				if (secActive) begin
					s_d.gain = SGB_GAIN_SECOND;
				end else if (cmdEnd && boostOk) begin
					enterThird = 1'b1;
				end
			end
			SGB_GAIN_SECOND: begin
				if (restoreReq) begin
					s_d.secInhibit = 1'b1;
					if (boostOk) begin
						enterThird = 1'b1;
						rampThird = 1'b1;
					end else begin
						s_d.gain = SGB_GAIN_FIRST;
					end
				end else if (!secActive) begin
					if (boostOk) begin
						enterThird = 1'b1;
						rampThird = 1'b1;
					end else begin
						s_d.gain = SGB_GAIN_FIRST;
					end
				end
			end
			SGB_GAIN_THIRD: begin
				if (!boostOk) begin
					s_d.gain = SGB_GAIN_FIRST;
				end else if (secActive) begin
					s_d.gain = SGB_GAIN_SECOND;
				end else if (tick) begin
					if (s_q.boostCnt + 14'h0001 >= s_q.interval) begin
						s_d.gain = SGB_GAIN_FIRST;
					end else begin
						s_d.boostCnt = s_q.boostCnt + 14'h0001;
					end
				end
			end
			default: s_d.gain = SGB_GAIN_FIRST;
		endcase
		if (enterThird) begin
			s_d.gain = SGB_GAIN_THIRD;
			s_d.boostCnt = '0;
			s_d.tickCnt = '0;
			s_d.rampLeft = rampThird ? s_q.trans : '0;
		end

		// applied gains; only position and speed proportional gains boost
		case (s_d.gain)
			SGB_GAIN_SECOND: begin
				s_d.posGain = secondGains.pos;
				s_d.velGain = secondGains.vel;
			end
			SGB_GAIN_THIRD: begin
				s_d.velGain = thirdVel;
				if (enterThird) begin
					s_d.posGain = (s_d.rampLeft != '0) ? s_q.posGain : thirdPos;
				end else if (s_q.rampLeft == '0) begin
					s_d.posGain = thirdPos;
				end else if (tick) begin
					// linear ramp: close the remaining gap in equal parts
					rampDiff = $signed({2'b00, thirdPos}) -
						$signed({2'b00, s_q.posGain});
					rampStep = rampDiff / $signed({4'b0000, s_q.rampLeft});
					s_d.posGain = s_q.posGain + rampStep[15:0];
					s_d.rampLeft = s_q.rampLeft - 14'h0001;
				end
			end
			default: begin
				s_d.posGain = firstGains.pos;
				s_d.velGain = firstGains.vel;
			end
		endcase
		if (s_d.gain != SGB_GAIN_THIRD) begin
			s_d.rampLeft = '0;
		end

		// compensation values, held through servo-on until a command starts
		if (servoOn && cmdStart) begin
			s_d.biasCur = s_q.bias;
			s_d.fricCur = posCmdFwd ? s_q.fwd : s_q.rev;
		end else if (servoOn && posCmdActive && posMode) begin
			s_d.fricCur = posCmdFwd ? s_q.fwd : s_q.rev;
		end

		// torque command with bias and friction terms, saturated
		torqueSum = 18'(torqueCmdIn);
		if (servoOn && s_q.mode != SGB_MODE_TRQ) begin
			torqueSum = torqueSum + 18'(s_q.biasCur);
		end
		if (servoOn && posMode) begin
			torqueSum = torqueSum + 18'(s_q.fricCur);
		end
		if (torqueSum > 18'sh07fff) begin
			s_d.torque = 16'sh7fff;
		end else if (torqueSum < -18'sh08000) begin
			s_d.torque = -16'sh8000;
		end else begin
			s_d.torque = torqueSum[15:0];
		end

		// address phase; only whole-word writes are taken
		s_d.ahbActive = accept;
		s_d.ahbWrite = hwrite && (hsize == SGB_HSIZE_WORD);
		s_d.ahbAddr = haddr[7:0];
		if (accept && !hwrite) begin
			s_d.rdata = regRead(s_d, haddr[7:0]);
		end
	end

	// single state register, frozen while the clock enable is low
	always_ff @(posedge clk) begin
		if (rst) begin
			s_q <= '0;
			s_q.scale <= SGB_SCALE_RST;
		end else if (ce) begin
			s_q <= s_d;
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	sequence sRestoreFromSecond;
		ce && wr && restoreReq && s_q.gain == SGB_GAIN_SECOND && boostOk;
	endsequence
	sequence sInThirdRamped;
		s_q.gain == SGB_GAIN_THIRD && s_q.rampLeft == $past(s_q.trans);
	endsequence
	sequence sCmdFinished;
		ce && cmdEnd && boostOk && !secondGainCond &&
			s_q.gain == SGB_GAIN_FIRST;
	endsequence

	AST_NO_THIRD_OUT_OF_POS: assert property (
		ce && !posMode |=> s_q.gain != SGB_GAIN_THIRD)
		else $error("third gain outside position control");
	AST_ZERO_TIME_NO_BOOST: assert property (
		ce && s_q.interval == '0 |=> s_q.gain != SGB_GAIN_THIRD)
		else $error("boost active with zero interval");
	AST_SECOND_OVERRIDES: assert property (
		ce && s_q.gain == SGB_GAIN_THIRD && boostOk && secondGainCond &&
			!s_q.secInhibit |=> s_q.gain == SGB_GAIN_SECOND)
		else $error("second gain did not take over boost");
	AST_CMD_END_OPENS: assert property (
		sCmdFinished |=> s_q.gain == SGB_GAIN_THIRD && s_q.boostCnt == '0)
		else $error("command end did not open boost");
	AST_RESTORE_OPENS: assert property (
		sRestoreFromSecond |=> sInThirdRamped)
		else $error("restore write did not open ramped boost");
	// a clipped gain only needs a product at or above the clip point
	AST_THIRD_VEL_GAIN: assert property (
		ce && s_q.gain == SGB_GAIN_THIRD && s_d.gain == SGB_GAIN_THIRD
			|=> ((s_q.velGain == SGB_GAIN_MAX) ?
			(26'($past(firstGains.vel)) * $past(s_q.scale) >=
				26'(SGB_GAIN_MAX) * SGB_SCALE_DIV) :
			(26'($past(firstGains.vel)) * $past(s_q.scale) / SGB_SCALE_DIV ==
				26'(s_q.velGain))))
		else $error("speed gain not third gain in boost");
	AST_THIRD_POS_SCALED: assert property (
		ce && s_q.gain == SGB_GAIN_THIRD && s_d.gain == SGB_GAIN_THIRD &&
			s_q.rampLeft == '0
			|=> ((s_q.posGain == SGB_GAIN_MAX) ?
			(26'($past(firstGains.pos)) * $past(s_q.scale) >=
				26'(SGB_GAIN_MAX) * SGB_SCALE_DIV) :
			(26'($past(firstGains.pos)) * $past(s_q.scale) / SGB_SCALE_DIV ==
				26'(s_q.posGain))))
		else $error("position gain not first gain times scale");
	AST_BOOST_EXPIRES: assert property (
		ce && s_q.gain == SGB_GAIN_THIRD && boostOk && !secActive && tick &&
			s_q.boostCnt + 14'h0001 >= s_q.interval
			|=> s_q.gain == SGB_GAIN_FIRST)
		else $error("boost outlived its interval");
	// kept clear of the saturation limits so the plain sum holds
	AST_POS_TORQUE_SUM: assert property (
		ce && servoOn && posMode && torqueCmdIn > -16'sh7000 &&
			torqueCmdIn < 16'sh7000
			|=> torqueCmdOut == $past(torqueCmdIn) +
			16'($past(s_q.biasCur)) + 16'($past(s_q.fricCur)))
		else $error("bias or friction term missing in position control");
	AST_RAMP_LOADED: assert property (
		ce && s_q.gain == SGB_GAIN_SECOND && s_d.gain == SGB_GAIN_THIRD
			|=> s_q.rampLeft == $past(s_q.trans))
		else $error("ramp not loaded on second to third");
	AST_TORQUE_MODE_PLAIN: assert property (
		ce && s_q.mode == SGB_MODE_TRQ |=> torqueCmdOut == $past(torqueCmdIn))
		else $error("compensation added in torque control");
	AST_HOLD_BEFORE_CMD: assert property (
		ce && !posCmdActive |=> s_q.biasCur == $past(s_q.biasCur))
		else $error("bias changed without a command");
	AST_RELOAD_ON_START: assert property (
		ce && servoOn && cmdStart |=> s_q.biasCur == $past(s_q.bias) &&
			s_q.fricCur == ($past(posCmdFwd) ? $past(s_q.fwd) : $past(s_q.rev)))
		else $error("compensation not reloaded at command start");
endmodule

// *** src/sgb_pkg.sv ***
/*
 * Shared constants, types and the register map of the servo gain boost
 * and friction compensation block.
 * Assumes a 125 MHz clock and an AHB-Lite master reaching a 256-byte window.
 */
package sgb_pkg;

	// register byte offsets within the window
	localparam logic [7:0] SGB_OFS_INTERVAL = 8'h00;
	localparam logic [7:0] SGB_OFS_SCALE = 8'h04;
	localparam logic [7:0] SGB_OFS_BIAS = 8'h08;
	localparam logic [7:0] SGB_OFS_FWD = 8'h0c;
	localparam logic [7:0] SGB_OFS_REV = 8'h10;
	localparam logic [7:0] SGB_OFS_TRANS = 8'h14;
	localparam logic [7:0] SGB_OFS_CTRL = 8'h18;
	localparam logic [7:0] SGB_OFS_STATUS = 8'h1c;

	// control and status field positions
	localparam int SGB_CTRL_MODE_LSB = 0;
	localparam int SGB_CTRL_RESTORE_BIT = 2;
	localparam int SGB_STAT_BIAS_LSB = 8;
	localparam int SGB_STAT_FRIC_LSB = 16;

	// reset values and fixed figures
	localparam logic [9:0] SGB_SCALE_RST = 10'h064;
	localparam logic [25:0] SGB_SCALE_DIV = 26'h0000064;
	localparam logic [15:0] SGB_GAIN_MAX = 16'hffff;
	localparam logic [2:0] SGB_HSIZE_WORD = 3'h2;

	// boost and ramp time unit, and its length in clock cycles
	localparam real SGB_TICK_MS = 0.1;
	localparam real SGB_CLK_MHZ = 125.0;
	localparam int SGB_TICK_CYCLES = int'(SGB_TICK_MS * 1000.0 * SGB_CLK_MHZ);

	typedef enum logic [1:0] {
		SGB_MODE_POS = 2'h0,
		SGB_MODE_VEL = 2'h1,
		SGB_MODE_TRQ = 2'h2,
		SGB_MODE_FULL = 2'h3
	} sgb_mode_t;

	// usual path first -> second -> third
	typedef enum logic [1:0] {
		SGB_GAIN_FIRST = 2'h0,
		SGB_GAIN_SECOND = 2'h1,
		SGB_GAIN_THIRD = 2'h3
	} sgb_gain_t;

	typedef struct packed {
		logic [15:0] pos;
		logic [15:0] vel;
	} sgb_gains_t;

	typedef struct packed {
		logic [13:0] interval;
		logic [9:0] scale;
		logic signed [7:0] bias;
		logic signed [7:0] fwd;
		logic signed [7:0] rev;
		logic [13:0] trans;
		sgb_mode_t mode;
		sgb_gain_t gain;
		logic [15:0] tickCnt;
		logic [13:0] boostCnt;
		logic [13:0] rampLeft;
		logic secInhibit;
		logic cmdPrev;
		logic signed [7:0] biasCur;
		logic signed [7:0] fricCur;
		logic [15:0] posGain;
		logic [15:0] velGain;
		logic signed [15:0] torque;
		logic ahbActive;
		logic ahbWrite;
		logic [7:0] ahbAddr;
		logic [31:0] rdata;
	} sgb_state_t;

endpackage

// *** dv/sgb_motion_ctrl.sv ***
/*
 * Behavioural model of the motion controller that issues position commands.
 * Assumes the bench asks for a command by pulsing cmdGo with a length.
 */
`timescale 1ns/1ns
module sgb_motion_ctrl (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// bench request
	input wire logic cmdGo,
	input wire logic cmdDir,
	input wire logic [7:0] cmdLen,
	// position command to the drive
	output logic posCmdActive,
	output logic posCmdFwd
);
	logic [7:0] cnt_q;
	logic dir_q;
	logic junk_q;

	// command length counter; the drive stays benignly configured around it
	always_ff @(posedge clk) begin
		junk_q <= ~junk_q;
		if (rst) begin
			cnt_q <= 8'h00;
			junk_q <= 1'b0;
		end else if (cmdGo) begin
			cnt_q <= cmdLen;
			dir_q <= cmdDir;
		end else if (cnt_q != 8'h00) begin
			cnt_q <= cnt_q - 8'h01;
		end
	end

	// direction is meaningless when idle, so it wobbles to catch misuse
	assign posCmdActive = (cnt_q != 8'h00);
	assign posCmdFwd = posCmdActive ? dir_q : junk_q;
endmodule

// *** dv/testbench.sv ***
/*
 * Self-checking bench for the gain boost and friction compensation block.
 * Assumes a single AHB-Lite slave and a short boost tick for simulation.
 */
`timescale 1ns/1ns
module testbench;
	import sgb_pkg::*;
	localparam int TK = 4;
	logic clk = 0, rst = 1, hsel = 0, hwrite = 0, servoOn = 0;
	logic secondGainCond = 0, cmdGo = 0, cmdDir = 0, ce = 1;
	logic [31:0] haddr = 0, hwdata = 0, hrdata, rd;
	logic [1:0] htrans = 0;
	logic [2:0] hsize = 3'h2;
	logic hreadyout, hresp, boostActive, posCmdActive, posCmdFwd;
	logic [7:0] cmdLen = 0;
	sgb_gains_t firstGains, secondGains, appliedGains, tg;
	logic signed [15:0] torqueCmdIn = 0, torqueCmdOut;
	int error_cnt = 0, total_checks = 0, seed = 80, n;
	logic signed [7:0] bv, fv, rv;
	logic [9:0] sc;

	sgb_servo_boost #(.TICK_CYCLES(TK)) DUT (.clk(clk), .rst(rst), .ce(ce),
		.hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
		.hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
		.hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
		.servoOn(servoOn), .secondGainCond(secondGainCond),
		.posCmdActive(posCmdActive), .posCmdFwd(posCmdFwd),
		.firstGains(firstGains), .secondGains(secondGains),
		.appliedGains(appliedGains), .boostActive(boostActive),
		.torqueCmdIn(torqueCmdIn), .torqueCmdOut(torqueCmdOut));

	sgb_motion_ctrl ctrl (.clk(clk), .rst(rst), .cmdGo(cmdGo),
		.cmdDir(cmdDir), .cmdLen(cmdLen), .posCmdActive(posCmdActive),
		.posCmdFwd(posCmdFwd));

	// free-running clock
	initial begin
		forever #4 clk = ~clk;
	end

	task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		total_checks++;
		if (g !== e) begin
			error_cnt++;
			$display("[ERR] %s expected %h seen %h", nm, e, g);
		end
	endtask

	// single word transfer; waits on hready in both phases
	task ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		hsel <= 1'b1;
		haddr <= {24'h000000, a};
		htrans <= 2'h2;
		hwrite <= w;
		hsize <= SGB_HSIZE_WORD;
		do @(posedge clk); while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge clk); while (hreadyout !== 1'b1);
		rd = hrdata;
	endtask

	// ends at the edge where the drive first sees the command gone
	task cmd(input logic dir, input int len);
		@(posedge clk);
		cmdGo <= 1'b1;
		cmdDir <= dir;
		cmdLen <= len[7:0];
		@(posedge clk);
		cmdGo <= 1'b0;
		repeat (len + 1) @(posedge clk);
	endtask

	// compensated torque after the pipeline has settled
	task trq(input logic signed [7:0] b, input logic signed [7:0] f);
		repeat (3) @(negedge clk);
		chk("torque", {16'h0000, 16'(torqueCmdIn + b + f)},
			{16'h0000, torqueCmdOut});
	endtask

	function automatic sgb_gains_t third(sgb_gains_t g, int s);
		sgb_gains_t t;
		int p, v;
		p = g.pos * s / 100;
		v = g.vel * s / 100;
		t.pos = (p > 65535) ? 16'hffff : p[15:0];
		t.vel = (v > 65535) ? 16'hffff : v[15:0];
		return t;
	endfunction

	task end_of_test;
		$display("checks %0d errors %0d", total_checks, error_cnt);
		if (error_cnt == 0 && total_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	// hang guard, far beyond the few hundred cycles the run needs
	initial begin
		#200000;
		error_cnt++;
		end_of_test;
	end

	initial begin
		firstGains = $random(seed);
		secondGains = $random(seed);
		repeat (8) @(posedge clk);
		rst <= 1'b0;
		ahb(0, SGB_OFS_SCALE, 0);
		chk("scale", 32'h00000064, rd);
		chk("resp", 0, hresp);
		ahb(0, SGB_OFS_INTERVAL, 0);
		chk("interval", 32'h00000000, rd);
		ahb(0, 8'h40, 0);
		chk("unmapped", 32'h00000000, rd);
		bv = $random(seed) % 101;
		fv = $random(seed) % 101;
		rv = $random(seed) % 101;
		torqueCmdIn <= 16'($random(seed) % 1000);
		servoOn <= 1'b1;
		ahb(1, SGB_OFS_BIAS, bv);
		ahb(1, SGB_OFS_FWD, fv);
		ahb(1, SGB_OFS_REV, rv);
		trq(0, 0);
		cmd(1, 5);
		trq(bv, fv);
		cmd(0, 3);
		trq(bv, rv);
		// velocity, torque and full-closed modes
		for (int m = 1; m < 4; m++) begin
			ahb(1, SGB_OFS_CTRL, m);
			trq((m == 2) ? 8'sh00 : bv, (m == 3) ? rv : 8'sh00);
		end
		ahb(1, SGB_OFS_CTRL, 0);
		ahb(1, SGB_OFS_BIAS, -bv);
		trq(bv, rv);
		cmd(1, 2);
		trq(-bv, fv);
		// boost before stop with a random scale
		sc = 10'(50 + $unsigned($random(seed)) % 951);
		tg = third(firstGains, sc);
		ahb(1, SGB_OFS_SCALE, sc);
		ahb(1, SGB_OFS_INTERVAL, 3);
		ahb(1, SGB_OFS_TRANS, 2);
		cmd(1, 4);
		@(negedge clk);
		chk("boost on", 1, boostActive);
		chk("third gains", tg, appliedGains);
		n = 0;
		while (boostActive === 1'b1 && n < 100) begin
			n++;
			@(negedge clk);
		end
		chk("boost length", 1, (n >= 3 * TK && n <= 3 * TK + 1));
		chk("first after", firstGains, appliedGains);
		// second gain cuts a boost short, then ramps back
		cmd(0, 2);
		secondGainCond <= 1'b1;
		@(posedge clk);
		@(negedge clk);
		chk("second gains", secondGains, appliedGains);
		chk("boost cut", 0, boostActive);
		@(posedge clk);
		secondGainCond <= 1'b0;
		@(posedge clk);
		@(negedge clk);
		chk("ramp boost", 1, boostActive);
		chk("ramp vel", tg.vel, appliedGains.vel);
		repeat (2 * TK + 2) @(negedge clk);
		chk("ramp end", tg.pos, appliedGains.pos);
		repeat (6) @(negedge clk);
		// restore from second by a control write
		@(posedge clk);
		secondGainCond <= 1'b1;
		repeat (3) @(posedge clk);
		ahb(1, SGB_OFS_CTRL, 32'h00000004);
		repeat (2) @(negedge clk);
		chk("restore boost", 1, boostActive);
		@(posedge clk);
		secondGainCond <= 1'b0;
		repeat (16) @(posedge clk);
		ahb(1, SGB_OFS_CTRL, 1);
		cmd(1, 3);
		@(negedge clk);
		chk("vel no boost", 0, boostActive);
		ahb(1, SGB_OFS_CTRL, 0);
		ahb(1, SGB_OFS_INTERVAL, 0);
		ahb(1, SGB_OFS_SCALE, 100);
		cmd(1, 3);
		@(negedge clk);
		chk("off no boost", 0, boostActive);
		chk("off gains", firstGains, appliedGains);
		// a low enable freezes all state and stalls the bus
		trq(-bv, fv);
		@(posedge clk);
		ce <= 1'b0;
		torqueCmdIn <= torqueCmdIn + 16'sh0040;
		repeat (4) @(negedge clk);
		chk("stall", 0, hreadyout);
		chk("frozen", {16'h0000, 16'(torqueCmdIn - 16'sh0040 - bv + fv)},
			{16'h0000, torqueCmdOut});
		@(posedge clk);
		ce <= 1'b1;
		trq(-bv, fv);
		end_of_test;
	end
endmodule
